// ===== shared/flash_host_pkg.sv
// package: constants and carriers for the flash host controller
package flash_host_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned ADDR_W         = 20;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned BLOCK_COUNT    = 16;
  localparam int unsigned BLOCK_BYTES    = 65536;
  localparam int unsigned BLOCK_SEL_LSB  = 16;
  localparam int unsigned READ_WAKE_NS   = 400;
  localparam int unsigned CMD_WAKE_NS    = 1000;
  localparam int unsigned READ_WAKE_CYC  =
    (READ_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CMD_WAKE_CYC   =
    (CMD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC     = 4;
  localparam int unsigned READ_CYC       = 6;
  // command codes are parameters of the top; these are plain defaults
  localparam logic [7:0] CMD_PROG_DEF    = 8'h40;
  localparam logic [7:0] CMD_ERASE_DEF   = 8'h20;
  localparam logic [7:0] CMD_CONFIRM_DEF = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND_DEF = 8'hB0;
  localparam logic [7:0] CMD_RESUME_DEF  = 8'hD0;
  localparam logic [7:0] CMD_STATUS_DEF  = 8'h70;
  localparam logic [7:0] CMD_READ_DEF    = 8'hFF;
  localparam logic [2:0] OP_READ         = 3'h0;
  localparam logic [2:0] OP_PROGRAM      = 3'h1;
  localparam logic [2:0] OP_ERASE        = 3'h2;
  localparam logic [2:0] OP_SUSPEND      = 3'h3;
  localparam logic [2:0] OP_RESUME       = 3'h4;
  localparam logic [2:0] OP_STATUS       = 3'h5;
  localparam logic [2:0] OP_POWERDOWN    = 3'h6;
  localparam logic [2:0] OP_WAKE         = 3'h7;

  typedef struct packed {
    logic [2:0]  op;
    logic [19:0] addr;
    logic [7:0]  data;
  } req_s;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [19:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } pins_s;
endpackage

// ===== core/bus_cycle.sv
// one timed write or read cycle on the flash pins
`timescale 1ns/1ps
module bus_cycle
  import flash_host_pkg::*;
#(
  parameter int unsigned STROBE = STROBE_CYC,
  parameter int unsigned RDLEN  = READ_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  dq_in,
  output pins_s            pins,
  output logic             done,
  output logic [7:0]       rdata
);
  logic [7:0] count;
  logic       active;
  logic       wr;

  // ==========================================================
  // sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count  <= 8'h00;
      active <= 1'b0;
      wr     <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      // a new cycle waits one edge after done so one start is one cycle
      if (start && !active && !done) begin
        active <= 1'b1;
        wr     <= is_write;
        count  <= 8'h00;
      end else if (active) begin
        count <= count + 8'h01;
        if (count == 8'((wr ? STROBE : RDLEN) + 1)) begin
          active <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0,
                 dq_out: '0, dq_oe: 1'b0};
    end else if (start && !active && !done) begin
      pins.addr   <= addr;
      pins.dq_out <= wdata;
      pins.dq_oe  <= is_write;
      pins.ce_n   <= 1'b0;
      pins.we_n   <= !is_write;
      pins.oe_n   <= is_write;
    end else if (active) begin
      // address and data held across the rising edge of the strobe
      if (wr && count == 8'(STROBE - 1))
        pins.we_n <= 1'b1;
      if (count == 8'((wr ? STROBE : RDLEN) + 1)) begin
        pins.ce_n  <= 1'b1;
        pins.oe_n  <= 1'b1;
        pins.dq_oe <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      rdata <= 8'h00;
    else if (active && !wr && count == 8'(RDLEN - 1))
      rdata <= dq_in;
  end
endmodule

// ===== core/flash_host.sv
// host controller that drives the flash pins for program, erase and read
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter logic [7:0] CMD_PROG    = CMD_PROG_DEF,
  parameter logic [7:0] CMD_ERASE   = CMD_ERASE_DEF,
  parameter logic [7:0] CMD_CONFIRM = CMD_CONFIRM_DEF,
  parameter logic [7:0] CMD_SUSPEND = CMD_SUSPEND_DEF,
  parameter logic [7:0] CMD_RESUME  = CMD_RESUME_DEF,
  parameter logic [7:0] CMD_STATUS  = CMD_STATUS_DEF,
  parameter logic [7:0] CMD_READ    = CMD_READ_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  req_s             req,
  input  wire logic [7:0]  dq_in,
  input  wire logic        ready_busy_output,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [7:0]       resp_data,
  output logic             erase_suspended,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [19:0]      addr,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  output logic             reset_powerdown_input
);
  typedef enum logic [3:0] {
    S_IDLE   = 4'b0000,
    S_CMD1   = 4'b0001,
    S_CMD2   = 4'b0011,
    S_BUSY   = 4'b0010,
    S_READ   = 4'b0110,
    S_DOWN   = 4'b0111,
    S_WAKE   = 4'b0101,
    S_SUSP   = 4'b0100,
    S_DONE   = 4'b1100
  } state_e;

  state_e      state;
  req_s        cur;
  logic [7:0]  wake_cnt;
  logic        reads_ok;
  logic        cmds_ok;
  logic        cyc_start;
  logic        cyc_write;
  logic [19:0] cyc_addr;
  logic [7:0]  cyc_data;
  logic        cyc_done;
  logic [7:0]  cyc_rdata;
  pins_s       pins;

  // first command code of an operation
  function automatic logic [7:0] first_cmd(input logic [2:0] op);
    case (op)
      OP_PROGRAM: first_cmd = CMD_PROG;
      OP_ERASE:   first_cmd = CMD_ERASE;
      OP_SUSPEND: first_cmd = CMD_SUSPEND;
      OP_RESUME:  first_cmd = CMD_RESUME;
      OP_STATUS:  first_cmd = CMD_STATUS;
      default:    first_cmd = CMD_READ;
    endcase
  endfunction

  // second write of an operation: data byte or confirm code
  function automatic logic [7:0] second_cmd(input req_s r);
    case (r.op)
      OP_PROGRAM: second_cmd = r.data;
      OP_ERASE:   second_cmd = CMD_CONFIRM;
      default:    second_cmd = r.data;
    endcase
  endfunction

  function automatic logic two_writes(input logic [2:0] op);
    two_writes = (op == OP_PROGRAM) || (op == OP_ERASE);
  endfunction

  // ==========================================================
  // pin cycle engine
  bus_cycle u_cycle (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (cyc_start),
    .is_write (cyc_write),
    .addr     (cyc_addr),
    .wdata    (cyc_data),
    .dq_in    (dq_in),
    .pins     (pins),
    .done     (cyc_done),
    .rdata    (cyc_rdata)
  );

  always_comb begin
    cyc_start = 1'b0;
    cyc_write = 1'b1;
    cyc_addr  = cur.addr;
    cyc_data  = first_cmd(cur.op);
    case (state)
      S_CMD1: cyc_start = 1'b1;
      S_CMD2: begin
        cyc_start = 1'b1;
        cyc_data  = second_cmd(cur);
      end
      S_READ: begin
        cyc_start = 1'b1;
        cyc_write = 1'b0;
      end
      default: cyc_start = 1'b0;
    endcase
  end

  // ==========================================================
  // wake timers after reset/powerdown release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_cnt <= 8'h00;
      reads_ok <= 1'b0;
      cmds_ok  <= 1'b0;
    end else if (!reset_powerdown_input) begin
      wake_cnt <= 8'h00;
      reads_ok <= 1'b0;
      cmds_ok  <= 1'b0;
    end else begin
      if (!cmds_ok)
        wake_cnt <= wake_cnt + 8'h01;
      if (wake_cnt >= 8'(READ_WAKE_CYC))
        reads_ok <= 1'b1;
      if (wake_cnt >= 8'(CMD_WAKE_CYC))
        cmds_ok <= 1'b1;
    end
  end

  // ==========================================================
  // main sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state                 <= S_DOWN;
      cur                   <= '0;
      req_ready             <= 1'b0;
      resp_valid            <= 1'b0;
      resp_data             <= 8'h00;
      erase_suspended       <= 1'b0;
      reset_powerdown_input <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      req_ready  <= 1'b0;
      case (state)
        S_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            cur       <= req;
            req_ready <= 1'b0;
            case (req.op)
              OP_POWERDOWN: begin
                reset_powerdown_input <= 1'b0;
                erase_suspended       <= 1'b0;
                state                 <= S_DONE;
              end
              OP_WAKE: begin
                if (!reset_powerdown_input)
                  state <= S_DOWN;
                else
                  state <= S_DONE;
              end
              OP_PROGRAM,
              OP_ERASE: begin
                if (reset_powerdown_input && ready_busy_output
                    && !erase_suspended)
                  state <= S_CMD1;
                else
                  state <= S_DONE;
              end
              OP_RESUME: begin
                if (erase_suspended && reset_powerdown_input)
                  state <= S_CMD1;
                else
                  state <= S_DONE;
              end
              default: begin
                // a read first writes the read-array code
                if (reset_powerdown_input)
                  state <= S_CMD1;
                else
                  state <= S_DONE;
              end
            endcase
          end
        end
        S_CMD1: begin
          if (cyc_done) begin
            if (two_writes(cur.op))
              state <= S_CMD2;
            else if (cur.op == OP_SUSPEND)
              state <= S_BUSY;
            else if (cur.op == OP_RESUME) begin
              erase_suspended <= 1'b0;
              state           <= S_DONE;
            end else
              state <= S_READ;
          end
        end
        S_CMD2: begin
          // erase goes to the block in addr[19:16]
          if (cyc_done)
            state <= S_BUSY;
        end
        S_BUSY: begin
          if (ready_busy_output) begin
            if (cur.op == OP_SUSPEND) begin
              erase_suspended <= 1'b1;
              state           <= S_SUSP;
            end else begin
              cur.op <= OP_STATUS;
              state  <= S_CMD1;
            end
          end
        end
        S_SUSP: state <= S_DONE;
        S_READ: begin
          if (cyc_done) begin
            resp_data <= cyc_rdata;
            state     <= S_DONE;
          end
        end
        S_DOWN: begin
          // leave powerdown after reset or on a wake request
          reset_powerdown_input <= 1'b1;
          state                 <= S_WAKE;
        end
        S_WAKE: begin
          if (cmds_ok && reads_ok)
            state <= S_DONE;
        end
        S_DONE: begin
          resp_valid <= 1'b1;
          state      <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // registered pin outputs; idle leaves chip select high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ce_n   <= 1'b1;
      oe_n   <= 1'b1;
      we_n   <= 1'b1;
      addr   <= 20'h0_0000;
      dq_out <= 8'h00;
      dq_oe  <= 1'b0;
    end else begin
      ce_n   <= pins.ce_n;
      oe_n   <= pins.oe_n;
      we_n   <= pins.we_n;
      addr   <= pins.addr;
      dq_out <= pins.dq_out;
      dq_oe  <= pins.dq_oe;
    end
  end
endmodule

// ===== sim/flash_host_monitor.sv
// checker: pin ordering of the flash host
`timescale 1ns/1ps
// ==========================================
// checker module
module flash_host_monitor
  import flash_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req_valid,
  input      logic req_ready,
  input      logic resp_valid,
  input      logic erase_suspended,
  input      logic ce_n,
  input      logic oe_n,
  input      logic we_n,
  input      logic dq_oe,
  input      logic reset_powerdown_input
);
  int unsigned up_cnt;
  // cycles since the flash was woken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      up_cnt <= 0;
    end else if (!reset_powerdown_input) begin
      up_cnt <= 0;
    end else if (up_cnt < 100) begin
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_pd_no_write: assert property (
    !reset_powerdown_input |-> we_n) else $error("strobe in powerdown");
  chk_cmd_wake_gap: assert property (
    !we_n |-> up_cnt >= CMD_WAKE_CYC) else $error("write too early");
  chk_read_wake_gap: assert property (
    !oe_n |-> up_cnt >= READ_WAKE_CYC) else $error("read too early");
  chk_strobe_selected: assert property (
    $rose(we_n) |-> $past(dq_oe) && !$past(ce_n))
    else $error("strobe edge without data");
  chk_read_no_fight: assert property (
    !oe_n |-> !dq_oe && !ce_n && we_n) else $error("read with drive");
  chk_resp_one_cycle: assert property (
    resp_valid |=> !resp_valid) else $error("long response");
  chk_one_request: assert property (
    req_valid && req_ready |=> !req_ready) else $error("second take");
  chk_pd_clears_susp: assert property (
    !reset_powerdown_input |=> !erase_suspended)
    else $error("suspend kept in powerdown");
  cov_write: cover property ($fell(we_n));
  cov_read: cover property ($fell(oe_n));
  cov_wake: cover property ($rose(reset_powerdown_input) ##[1:300] !we_n);
endmodule

bind flash_host flash_host_monitor mon (
  .core_clk(core_clk), .rst(rst), .req_valid(req_valid),
  .req_ready(req_ready), .resp_valid(resp_valid),
  .erase_suspended(erase_suspended), .ce_n(ce_n), .oe_n(oe_n),
  .we_n(we_n), .dq_oe(dq_oe),
  .reset_powerdown_input(reset_powerdown_input));

// ===== sim/flash_model.sv
// behavioural flash device on the host pins
`timescale 1ns/1ps
// ==========================================
// flash model
module flash_model
  import flash_host_pkg::*;
#(
  parameter int PROG_T  = 400,
  parameter int ERASE_T = 2000
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  dq_out,
  input  wire logic        reset_powerdown_input,
  output logic [7:0]       dq_in,
  output logic             ready_busy_output
);
  logic [7:0]  mem [0:1048575];
  logic [7:0]  pend    = 8'h00;
  logic [7:0]  junk    = 8'ha5;
  logic [19:0] op_a    = 20'h0_0000;
  logic [7:0]  op_d    = 8'hff;
  logic        erase   = 1'b0;
  logic        susp    = 1'b0;
  logic        mode_st = 1'b0;
  logic        rd_wake = 1'b0;
  int          rem     = 0;
  realtime     t_up    = 0;
  wire         busy    = reset_powerdown_input && rem > 0 && !susp;
  assign ready_busy_output = !busy;
  // status byte: ready, suspended
  // deselected, disabled or still waking shows junk
  assign dq_in = (!ce_n && !oe_n && reset_powerdown_input && rd_wake) ?
    (mode_st ? {!busy, susp, 6'h00} : mem[addr]) : junk;
  initial for (int i = 0; i < 1048576; i++) mem[i] = 8'hff;
  // powerdown resets the engine and status
  always @(reset_powerdown_input) begin
    t_up = $realtime;
    rem = 0;
    susp = 1'b0;
    pend = 8'h00;
    mode_st = 1'b0;
  end
  // self-timed engine
  always #20 begin
    junk = ~junk;
    rd_wake = $realtime - t_up >= READ_WAKE_NS;
    if (busy) begin
      rem--;
      if (rem == 0 && erase)
        for (int i = 0; i < BLOCK_BYTES; i++)
          mem[{op_a[19:16], i[15:0]}] = 8'hff;
      else if (rem == 0)
        mem[op_a] = mem[op_a] & op_d;
    end
  end
  always @(posedge we_n) begin
    logic [7:0] p;
    p = pend;
    pend = 8'h00;
    if (!ce_n && reset_powerdown_input
        && $realtime - t_up >= CMD_WAKE_NS) begin
      if (p == CMD_PROG_DEF
          || (p == CMD_ERASE_DEF && dq_out == CMD_CONFIRM_DEF)) begin
        op_a = addr;
        op_d = dq_out;
        erase = p == CMD_ERASE_DEF;
        rem = erase ? ERASE_T : PROG_T;
        mode_st = 1'b1;
      end else begin
        case (dq_out)
          CMD_PROG_DEF, CMD_ERASE_DEF: if (rem == 0) pend = dq_out;
          CMD_SUSPEND_DEF: if (busy && erase) susp = 1'b1;
          CMD_RESUME_DEF: susp = 1'b0;
          CMD_STATUS_DEF: mode_st = 1'b1;
          CMD_READ_DEF: mode_st = 1'b0;
          default: ;
        endcase
      end
    end
  end
endmodule

// ===== sim/flash_host_tb.sv
// testbench: flash host against the flash model
`timescale 1ns/1ps
// ==========================================
// bench top
module flash_host_tb;
  import flash_host_pkg::*;
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic        req_valid = 1'b0;
  req_s        req       = '0;
  logic [7:0]  dq_in, resp_data, dq_out;
  logic [19:0] addr;
  logic        rdy, req_ready, resp_valid, susp, ce_n, oe_n, we_n;
  logic        dq_oe, rpd;
  int          failures  = 0;
  int          tests_run = 0;
  int          wr_cnt    = 0;
  always #10 core_clk = ~core_clk;
  always @(negedge we_n) wr_cnt++;
  flash_host dut (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req(req), .dq_in(dq_in), .ready_busy_output(rdy),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .erase_suspended(susp), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .reset_powerdown_input(rpd));
  flash_model fm (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_out(dq_out), .reset_powerdown_input(rpd), .dq_in(dq_in),
    .ready_busy_output(rdy));
  task automatic results();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic issue(input logic [2:0] op, input logic [19:0] a,
                       input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #1 n++;
    end
    req_valid = 1'b1;
    req = '{op: op, addr: a, data: d};
    @(posedge core_clk);
    #1 req_valid = 1'b0;
    while (resp_valid !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 20000) begin
      failures++;
      results();
    end
  endtask
  // program, then reprogram only the bit that turns to 0
  task automatic sc_program();
    issue(OP_PROGRAM, 20'h3_0010, 8'hbd);
    check(resp_data, 8'h80);
    issue(OP_READ, 20'h3_0010, 8'h00);
    check(resp_data, 8'hbd);
    issue(OP_PROGRAM, 20'h3_0010, 8'hfe);
    issue(OP_READ, 20'h3_0010, 8'h00);
    check(resp_data, 8'hbc);
  endtask
  // erase the block just below a programmed one
  task automatic sc_erase();
    issue(OP_PROGRAM, 20'h2_ffff, 8'h12);
    issue(OP_ERASE, 20'h2_0000, 8'h00);
    check(resp_data, 8'h80);
    issue(OP_READ, 20'h2_ffff, 8'h00);
    check(resp_data, 8'hff);
    issue(OP_READ, 20'h3_0010, 8'h00);
    check(resp_data, 8'hbc);
  endtask
  // resume with nothing suspended makes no pin activity; status read
  task automatic sc_refuse();
    int w;
    w = wr_cnt;
    issue(OP_RESUME, 20'h0_0000, 8'h00);
    check(8'(wr_cnt - w), 8'h00);
    check({7'h00, susp}, 8'h00);
    issue(OP_STATUS, 20'h0_0000, 8'h00);
    check(resp_data, 8'h80);
  endtask
  // powerdown, refused program, wake, then the array reads back
  task automatic sc_power();
    int w;
    issue(OP_POWERDOWN, 20'h0_0000, 8'h00);
    check({7'h00, rpd}, 8'h00);
    check({7'h00, rdy}, 8'h01);
    w = wr_cnt;
    issue(OP_PROGRAM, 20'h3_0010, 8'h00);
    check(8'(wr_cnt - w), 8'h00);
    issue(OP_WAKE, 20'h0_0000, 8'h00);
    check({7'h00, rpd}, 8'h01);
    issue(OP_READ, 20'h3_0010, 8'h00);
    check(resp_data, 8'hbc);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    sc_program();
    sc_erase();
    sc_refuse();
    sc_power();
    results();
  end
endmodule
